// file: core/chap_host_port.sv
// Functional notes
// - Card modes decode address with attribute select
// - Task-file uses only three lowest address bits
// - Battery detect one held high, memory mode
// - Alert low on ready or protect change, I/O mode
// - Alert enabled by configuration register bit
// - Pass-diagnostic is two-way master/slave handshake
// - Task-file bytes on D[7:0], data 16-bit
`timescale 1ns/1ps
module chap_host_port
(
  input wire logic clk,
  input wire logic reset_n,
  input wire chap_pkg::chap_mode_t mode,
  input wire logic [10:0] address,
  input wire logic attribute_select_n,
  input wire logic low_byte_chip_enable_n,
  input wire logic high_byte_chip_enable_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_cycle,
  input wire logic card_ready,
  input wire logic write_protect,
  input wire logic status_change_enable,
  input wire logic pass_diagnostic_drive,
  input wire logic pass_diagnostic_n_in,
  output logic access_valid_q,
  output chap_pkg::chap_target_t access_target_q,
  output logic [10:0] access_offset_q,
  output logic [2:0] task_register_q,
  output logic byte_lane_low_only_q,
  output logic wide_access_q,
  output logic odd_wide_access_q,
  output logic battery_level_detect_one,
  output logic battery_level_detect_one_oe,
  output logic status_change_alert_n,
  output logic status_change_alert_n_oe,
  output logic pass_diagnostic_n_out,
  output logic pass_diagnostic_n_oe,
  output logic pass_diagnostic_seen_n_q
);

  // Pin synchronisers: two flops before any logic
  logic [10:0] addr_s1_q, addr_s2_q;
  logic [4:0] ctl_s1_q, ctl_s2_q;
  logic [1:0] st_s1_q, st_s2_q;
  logic pass_diagnostic_n_s1_q, pass_diagnostic_n_s2_q;
  logic [1:0] st_prev_q;
  logic [2:0] st_arm_q;
  logic strobe_prev_q;
  logic card_mode;
  logic strobe_active;
  logic strobe_start;

  function automatic chap_pkg::chap_target_t chap_decode(input logic [10:0] a, input logic attr_n);
    chap_pkg::chap_target_t t;
    t = chap_pkg::CHAP_T_NONE;
    if (!attr_n)
      t = (a >= chap_pkg::CHAP_CONFIG_BASE) ? chap_pkg::CHAP_T_CONFIG : chap_pkg::CHAP_T_CIS;
    else if (a < chap_pkg::CHAP_MEM_REG_LIMIT)
      t = chap_pkg::CHAP_T_MEM_REG;
    return t;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      addr_s1_q <= 11'h000;
      addr_s2_q <= 11'h000;
      ctl_s1_q <= 5'h1F;
      ctl_s2_q <= 5'h1F;
      st_s1_q <= 2'h0;
      st_s2_q <= 2'h0;
      pass_diagnostic_n_s1_q <= 1'h1;
      pass_diagnostic_n_s2_q <= 1'h1;
    end
    else
    begin
      addr_s1_q <= address;
      addr_s2_q <= addr_s1_q;
      ctl_s1_q <= {attribute_select_n, low_byte_chip_enable_n, high_byte_chip_enable_n,
                   read_strobe_n, write_strobe_n};
      ctl_s2_q <= ctl_s1_q;
      st_s1_q <= {card_ready, write_protect};
      st_s2_q <= st_s1_q;
      pass_diagnostic_n_s1_q <= pass_diagnostic_n_in;
      pass_diagnostic_n_s2_q <= pass_diagnostic_n_s1_q;
    end
  end

  assign card_mode = (mode != chap_pkg::CHAP_TASK);
  assign strobe_active = !(ctl_s2_q[3] && ctl_s2_q[2]) && !(ctl_s2_q[1] && ctl_s2_q[0]);
  assign strobe_start = strobe_active && !strobe_prev_q;

  // Address is captured only at the start of an enabled strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      strobe_prev_q <= 1'h0;
      access_valid_q <= 1'h0;
      access_target_q <= chap_pkg::CHAP_T_NONE;
      access_offset_q <= 11'h000;
      task_register_q <= 3'h0;
      byte_lane_low_only_q <= 1'h0;
      wide_access_q <= 1'h0;
      odd_wide_access_q <= 1'h0;
    end
    else
    begin
      strobe_prev_q <= strobe_active;
      access_valid_q <= strobe_start;
      if (strobe_start)
      begin
        wide_access_q <= !ctl_s2_q[3] && !ctl_s2_q[2];
        if (card_mode)
        begin
          // Once the I/O interface is configured, common space holds the I/O port registers
          if (mode == chap_pkg::CHAP_IO && ctl_s2_q[4])
            access_target_q <= chap_pkg::CHAP_T_IO_REG;
          else
            access_target_q <= chap_decode(addr_s2_q, ctl_s2_q[4]);
          access_offset_q <= addr_s2_q;
          // Flagged only; the host must not issue this combination
          odd_wide_access_q <= !ctl_s2_q[3] && !ctl_s2_q[2] && addr_s2_q[0];
          byte_lane_low_only_q <= 1'h0;
        end
        else
        begin
          access_target_q <= chap_pkg::CHAP_T_NONE;
          access_offset_q <= {8'h00, addr_s2_q[2:0]};
          task_register_q <= addr_s2_q[2:0];
          odd_wide_access_q <= 1'h0;
          // Registers move as bytes, data port uses the full word
          byte_lane_low_only_q <= !data_cycle;
        end
      end
    end
  end

  // Alert is a one-cycle low pulse per change, not a latched level
  // Status syncs refill after reset; comparing before then would flag a change that never happened
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_prev_q <= 2'h0;
      st_arm_q <= 3'h0;
      status_change_alert_n <= chap_pkg::CHAP_ALERT_IDLE_N;
      status_change_alert_n_oe <= 1'h0;
      battery_level_detect_one <= chap_pkg::CHAP_BATT_LEVEL;
      battery_level_detect_one_oe <= 1'h0;
    end
    else
    begin
      st_prev_q <= st_s2_q;
      st_arm_q <= {st_arm_q[1:0], 1'h1};
      battery_level_detect_one <= chap_pkg::CHAP_BATT_LEVEL;
      battery_level_detect_one_oe <= (mode == chap_pkg::CHAP_MEM);
      status_change_alert_n_oe <= (mode == chap_pkg::CHAP_IO);
      if (mode == chap_pkg::CHAP_IO && status_change_enable && st_arm_q[2] && st_prev_q != st_s2_q)
        status_change_alert_n <= 1'h0;
      else
        status_change_alert_n <= chap_pkg::CHAP_ALERT_IDLE_N;
    end
  end

  // Open-drain style: drive low only when told, sample only in task mode
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pass_diagnostic_n_out <= 1'h1;
      pass_diagnostic_n_oe <= 1'h0;
      pass_diagnostic_seen_n_q <= 1'h1;
    end
    else
    begin
      pass_diagnostic_n_out <= 1'h0;
      pass_diagnostic_n_oe <= (mode == chap_pkg::CHAP_TASK) && pass_diagnostic_drive;
      pass_diagnostic_seen_n_q <= (mode == chap_pkg::CHAP_TASK) ? pass_diagnostic_n_s2_q : 1'h1;
    end
  end

  battery_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode == chap_pkg::CHAP_MEM |=> battery_level_detect_one && battery_level_detect_one_oe)
    else $error("battery detect not driven high");

  alert_change_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode == chap_pkg::CHAP_IO && status_change_enable && st_arm_q[2] && st_prev_q != st_s2_q
    |=> !status_change_alert_n)
    else $error("alert missed a status change");

  alert_io_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode != chap_pkg::CHAP_IO |=> status_change_alert_n && !status_change_alert_n_oe)
    else $error("alert active outside I/O mode");

  io_target_a: assert property (@(posedge clk) disable iff (!reset_n)
    strobe_start && mode == chap_pkg::CHAP_IO && ctl_s2_q[4] |=> access_target_q == chap_pkg::CHAP_T_IO_REG)
    else $error("I/O access not sent to port registers");

  alert_masked_a: assert property (@(posedge clk) disable iff (!reset_n)
    !status_change_enable |=> status_change_alert_n)
    else $error("alert asserted while disabled");

  task_reg_a: assert property (@(posedge clk) disable iff (!reset_n)
    strobe_start && !card_mode |=> task_register_q == $past(addr_s2_q[2:0]) && access_offset_q[10:3] == 8'h00)
    else $error("task register select wrong");

  idle_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !strobe_start |=> $stable(access_offset_q) && !access_valid_q)
    else $error("address taken outside a strobe");

  card_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
    strobe_start && card_mode |=> access_offset_q == $past(addr_s2_q))
    else $error("card mode offset wrong");

  odd_wide_a: assert property (@(posedge clk) disable iff (!reset_n)
    odd_wide_access_q |-> wide_access_q && access_offset_q[0])
    else $error("odd wide flag inconsistent");

  byte_lane_a: assert property (@(posedge clk) disable iff (!reset_n)
    strobe_start && !card_mode && !data_cycle |=> byte_lane_low_only_q)
    else $error("task register not byte wide");

  pass_diagnostic_n_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode != chap_pkg::CHAP_TASK |=> !pass_diagnostic_n_oe)
    else $error("diagnostic pin driven outside task mode");

endmodule

// file: core/chap_pkg.sv
package chap_pkg;
  // Interface mode, one-hot
  typedef enum logic [2:0]
  {
    CHAP_MEM = 3'h1,
    CHAP_IO = 3'h2,
    CHAP_TASK = 3'h4
  } chap_mode_t;

  // Decoded target of a card-mode access
  typedef enum logic [3:0]
  {
    CHAP_T_NONE = 4'h0,
    CHAP_T_IO_REG = 4'h1,
    CHAP_T_MEM_REG = 4'h2,
    CHAP_T_CIS = 4'h4,
    CHAP_T_CONFIG = 4'h8
  } chap_target_t;

  localparam int CHAP_ADDR_W = 11;
  localparam int CHAP_TASK_W = 3;
  // Attribute space: CIS below this offset, configuration registers at and above
  localparam logic [10:0] CHAP_CONFIG_BASE = 11'h200;
  // Register file window within common memory space
  localparam logic [10:0] CHAP_MEM_REG_LIMIT = 11'h010;
  localparam logic CHAP_BATT_LEVEL = 1'h1;
  localparam logic CHAP_ALERT_IDLE_N = 1'h1;
endpackage

// file: dv/chap_host_model.sv
`timescale 1ns/1ps
module chap_host_model
(
  input wire logic clk,
  output logic [10:0] address,
  output logic attribute_select_n,
  output logic low_byte_chip_enable_n,
  output logic high_byte_chip_enable_n,
  output logic read_strobe_n,
  output logic write_strobe_n
);
  initial
  begin
    address = 11'h000;
    attribute_select_n = 1'h1;
    low_byte_chip_enable_n = 1'h1;
    high_byte_chip_enable_n = 1'h1;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
  end

  // Held five cycles, past the answer; the gap lets the input syncs see an idle strobe
  task automatic access(input logic [10:0] a, input logic attr_n, input logic wide, input logic wr);
    @(negedge clk);
    address = a;
    attribute_select_n = attr_n;
    low_byte_chip_enable_n = 1'h0;
    high_byte_chip_enable_n = ~wide;
    read_strobe_n = wr;
    write_strobe_n = ~wr;
    repeat (3) @(negedge clk);
    // Lines wiggle mid-strobe and stay wiggled once released, as a floating bus would
    address = ~a;
    repeat (2) @(negedge clk);
    low_byte_chip_enable_n = 1'h1;
    high_byte_chip_enable_n = 1'h1;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
    attribute_select_n = 1'h1;
    repeat (3) @(negedge clk);
  endtask
endmodule

// file: dv/tb_card_host_address_status_pins.sv
`timescale 1ns/1ps
module tb_card_host_address_status_pins;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  chap_pkg::chap_mode_t mode = chap_pkg::CHAP_MEM;
  logic data_cycle = 1'h0;
  logic card_ready = 1'h0;
  logic write_protect = 1'h0;
  logic status_change_enable = 1'h0;
  logic pass_diagnostic_drive = 1'h0;
  logic other_pass_diagnostic_n_n = 1'h1;
  logic [10:0] address;
  logic attr_n, ce_lo_n, ce_hi_n, rd_n, wr_n;
  logic valid, batt, batt_oe, alert_n, alert_oe, pd_out, pd_oe, pd_seen_n, lane_lo, wide, odd_wide;
  chap_pkg::chap_target_t target;
  logic [10:0] offset;
  logic [2:0] task_reg;
  wire pass_diagnostic_n_pin = (pd_oe ? pd_out : 1'h1) & other_pass_diagnostic_n_n;
  int fail_count = 0;
  int n_compared = 0;
  int n_valid = 0;
  int n_alert = 0;

  initial
  begin
    forever #2 clk = ~clk;
  end

  chap_host_model host (.clk(clk), .address(address), .attribute_select_n(attr_n), .low_byte_chip_enable_n(ce_lo_n),
    .high_byte_chip_enable_n(ce_hi_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n));

  chap_host_port dut (.clk(clk), .reset_n(reset_n), .mode(mode), .address(address), .attribute_select_n(attr_n),
    .low_byte_chip_enable_n(ce_lo_n), .high_byte_chip_enable_n(ce_hi_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .data_cycle(data_cycle), .card_ready(card_ready), .write_protect(write_protect),
    .status_change_enable(status_change_enable), .pass_diagnostic_drive(pass_diagnostic_drive),
    .pass_diagnostic_n_in(pass_diagnostic_n_pin), .access_valid_q(valid), .access_target_q(target), .access_offset_q(offset),
    .task_register_q(task_reg), .byte_lane_low_only_q(lane_lo), .wide_access_q(wide), .odd_wide_access_q(odd_wide),
    .battery_level_detect_one(batt), .battery_level_detect_one_oe(batt_oe), .status_change_alert_n(alert_n),
    .status_change_alert_n_oe(alert_oe), .pass_diagnostic_n_out(pd_out), .pass_diagnostic_n_oe(pd_oe),
    .pass_diagnostic_seen_n_q(pd_seen_n));

  always @(posedge clk)
  begin
    n_valid <= n_valid + (valid === 1'h1);
    n_alert <= n_alert + (alert_n === 1'h0);
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic test_memory_mode();
    int v;
    v = n_valid;
    check(batt, 1'h1);
    check(batt_oe, 1'h1);
    host.access(11'h7FF, 1'h1, 1'h1, 1'h0);
    check(11'(n_valid - v), 11'h001);
    check(offset, 11'h7FF);
    check(target, chap_pkg::CHAP_T_NONE);
    check(wide, 1'h1);
    check(odd_wide, 1'h1);
    host.access(11'h20A, 1'h0, 1'h0, 1'h1);
    check(offset, 11'h20A);
    check(target, chap_pkg::CHAP_T_CONFIG);
    check(odd_wide, 1'h0);
    host.access(11'h00E, 1'h1, 1'h0, 1'h0);
    check(target, chap_pkg::CHAP_T_MEM_REG);
    host.access(11'h1FF, 1'h0, 1'h0, 1'h0);
    check(target, chap_pkg::CHAP_T_CIS);
    $display("test_memory_mode done");
  endtask

  task automatic test_task_mode();
    @(negedge clk);
    mode = chap_pkg::CHAP_TASK;
    pass_diagnostic_drive = 1'h1;
    repeat (4) @(negedge clk);
    check(pd_oe, 1'h1);
    check(pass_diagnostic_n_pin, 1'h0);
    pass_diagnostic_drive = 1'h0;
    other_pass_diagnostic_n_n = 1'h0;
    repeat (4) @(negedge clk);
    check(pd_oe, 1'h0);
    check(pd_seen_n, 1'h0);
    other_pass_diagnostic_n_n = 1'h1;
    repeat (4) @(negedge clk);
    check(pd_seen_n, 1'h1);
    host.access(11'h7FD, 1'h1, 1'h0, 1'h0);
    check(task_reg, 3'h5);
    check(offset, 11'h005);
    check(target, chap_pkg::CHAP_T_NONE);
    check(lane_lo, 1'h1);
    data_cycle = 1'h1;
    host.access(11'h002, 1'h1, 1'h1, 1'h1);
    check(task_reg, 3'h2);
    check(lane_lo, 1'h0);
    $display("test_task_mode done");
  endtask

  task automatic test_alert();
    int a;
    mode = chap_pkg::CHAP_IO;
    status_change_enable = 1'h1;
    repeat (6) @(negedge clk);
    check(alert_oe, 1'h1);
    check(batt_oe, 1'h0);
    host.access(11'h007, 1'h1, 1'h0, 1'h0);
    check(target, chap_pkg::CHAP_T_IO_REG);
    a = n_alert;
    card_ready = 1'h1;
    repeat (8) @(negedge clk);
    write_protect = 1'h1;
    repeat (8) @(negedge clk);
    check(11'(n_alert - a), 11'h002);
    status_change_enable = 1'h0;
    card_ready = 1'h0;
    repeat (8) @(negedge clk);
    check(11'(n_alert - a), 11'h002);
    mode = chap_pkg::CHAP_MEM;
    status_change_enable = 1'h1;
    repeat (2) @(negedge clk);
    card_ready = 1'h1;
    repeat (8) @(negedge clk);
    check(alert_oe, 1'h0);
    check(11'(n_alert - a), 11'h002);
    $display("test_alert done");
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    reset_n = 1'h1;
    repeat (3) @(negedge clk);
    test_memory_mode();
    test_task_mode();
    test_alert();
    tally_and_finish();
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
